// ---- rtl/ebm_pkg.sv ----
// Package with the constants and types of the external bus mastership block.
// Functional notes
// - With grant, wait for busy released first.
// - Grant removed: release after current bus cycle.
// - Async arbitration bit 13 adds input synchronisers.
// - New master waits idle busy, then asserts it.
// - Master may park, holding busy asserted.
// - Busy release: drive high briefly, then float.
// - Master drives active-low column strobe.
// - Not master, drive bit clear: strobe floats.
// - Bus clock only when master and tracing.
// - Locked bus clock leads core clock quarter period.
// - Complementary clock inverted while master, else floats.
// - Request asserted while bus is needed; in stop or wait it follows the hold bit instead.
// - Reset deasserts request, arbitration becomes slave.
// - Request-hold bit forces request asserted.
package ebm_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_MODE   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;

    // ----------------------------------------------------------------
    // Mode register fields
    // ----------------------------------------------------------------
    localparam int          MODE_COL_DRIVE_BIT   = 0;
    localparam int          MODE_REQ_HOLD_BIT    = 1;
    localparam int          MODE_TRACE_BIT       = 6;
    localparam int          MODE_ASYNC_ARB_BIT   = 13;
    localparam logic [31:0] MODE_RESET           = 32'h0000_0000;
    localparam logic [31:0] MODE_WRITE_MASK      = 32'h0000_2043;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int STAT_MASTER_BIT  = 0;
    localparam int STAT_REQUEST_BIT = 1;
    localparam int STAT_GRANT_BIT   = 2;
    localparam int STAT_BUSY_BIT    = 3;
    localparam int STAT_STATE_LSB   = 4;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS   = 10;
    localparam int BUSY_PULLUP_NS    = 10;
    localparam int BUSY_PULLUP_CYCLES =
        (BUSY_PULLUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS < 1 ? 1 :
        (BUSY_PULLUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ARB_SLAVE,
        ARB_MASTER,
        ARB_RELEASE
    } ebm_arb_type;

    typedef struct packed {
        logic asyncArbitrationEnable;
        logic traceEnable;
        logic requestHoldBit;
        logic columnStrobeDriveEnable;
    } ebm_mode_type;

    typedef struct packed {
        logic level;
        logic oe;
    } ebm_pin_type;

endpackage

// ---- rtl/ebm_bus_mastership.sv ----
// External bus mastership logic: arbitration, parking, column strobe, bus clock and APB registers.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module ebm_bus_mastership
#(
    parameter int PULLUP_CYCLES = ebm_pkg::BUSY_PULLUP_CYCLES
)
(
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               linkClock,
    // APB slave.
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Core side.
    input  wire logic               busNeed,
    input  wire logic               cycleActive,
    input  wire logic               columnStrobeAssert,
    input  wire logic               lowPower,
    output logic                    isMaster,
    // Pins.
    input  wire logic               bus_grant_in_n,
    input  wire logic               bus_busy_line_in,
    output ebm_pkg::ebm_pin_type    bus_busy_line_out,
    output logic                    bus_request_out_n,
    output ebm_pkg::ebm_pin_type    columnStrobeN,
    output ebm_pkg::ebm_pin_type    busClock,
    output ebm_pkg::ebm_pin_type    busClockN
);
    import ebm_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0]  modeReg;
    ebm_mode_type mode;
    ebm_arb_type  arbState;
    logic         grantMeta;
    logic         grantSync;
    logic         grantSync2;
    logic         busyMeta;
    logic         busySync;
    logic         busySync2;
    logic         grantSeen;
    logic         busyHighSeen;
    logic [7:0]   pullupCount;

    assign mode.asyncArbitrationEnable  = modeReg[MODE_ASYNC_ARB_BIT];
    assign mode.traceEnable             = modeReg[MODE_TRACE_BIT];
    assign mode.requestHoldBit          = modeReg[MODE_REQ_HOLD_BIT];
    assign mode.columnStrobeDriveEnable = modeReg[MODE_COL_DRIVE_BIT];

    function automatic logic addrHit(input logic [11:0] a, input logic [11:0] reg_addr);
        addrHit = (a == reg_addr);
    endfunction

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Zero wait states: every access completes in its first access cycle.
    logic mapped;

    assign mapped  = addrHit(paddr, ADDR_MODE) || addrHit(paddr, ADDR_STATUS);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            modeReg <= MODE_RESET;
        else if (psel && penable && pwrite && addrHit(paddr, ADDR_MODE))
            modeReg <= pwdata & MODE_WRITE_MASK;
    end

    // Read data is captured in the setup cycle so that it comes from a flip-flop.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            if (addrHit(paddr, ADDR_MODE))
                prdata <= modeReg;
            else if (addrHit(paddr, ADDR_STATUS))
            begin
                prdata                                   <= 32'h0000_0000;
                prdata[STAT_MASTER_BIT]                  <= (arbState == ARB_MASTER);
                prdata[STAT_REQUEST_BIT]                 <= !bus_request_out_n;
                prdata[STAT_GRANT_BIT]                   <= grantSeen;
                prdata[STAT_BUSY_BIT]                    <= !busyHighSeen;
                prdata[STAT_STATE_LSB +: 2]              <= arbState;
            end
            else
                prdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Grant and busy input sampling
    // ----------------------------------------------------------------
    // Two flops always guard against metastability on the pins; the
    // asynchronous mode adds a third stage, trading a cycle of latency
    // for freedom from setup and hold limits.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            grantMeta  <= 1'b0;
            grantSync  <= 1'b0;
            grantSync2 <= 1'b0;
            busyMeta   <= 1'b0;
            busySync   <= 1'b0;
            busySync2  <= 1'b0;
        end
        else
        begin
            grantMeta  <= !bus_grant_in_n;
            grantSync  <= grantMeta;
            grantSync2 <= grantSync;
            busyMeta   <= bus_busy_line_in;
            busySync   <= busyMeta;
            busySync2  <= busySync;
        end
    end

    // Inputs are ignored in stop or wait by treating grant as absent.
    // A master in standby therefore gives the bus up once its cycle ends.
    always_comb
    begin
        grantSeen    = mode.asyncArbitrationEnable ? grantSync2 : grantSync;
        busyHighSeen = mode.asyncArbitrationEnable ? busySync2 : busySync;
        if (lowPower)
            grantSeen = 1'b0;
    end

    // ----------------------------------------------------------------
    // Arbitration decode
    // ----------------------------------------------------------------
    // Decoded once so that the state, the master flag and the busy drive
    // can never disagree about a take or a release.
    logic takeNow;
    logic releaseNow;
    logic pullupDone;

    assign takeNow    = grantSeen && busNeed && busyHighSeen;
    assign releaseNow = !grantSeen && !cycleActive;
    assign pullupDone = (pullupCount <= 8'h01);

    // ----------------------------------------------------------------
    // Arbitration state machine
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            arbState    <= ARB_SLAVE;
            pullupCount <= 8'h00;
        end
        else
        begin
            case (arbState)
                ARB_SLAVE:
                begin
                    // Mastership is taken only once the line is seen idle.
                    if (takeNow)
                        arbState <= ARB_MASTER;
                end
                ARB_MASTER:
                begin
                    // Without grant, let the running cycle finish; with grant
                    // the bus stays parked even when no longer needed.
                    if (releaseNow)
                    begin
                        arbState    <= ARB_RELEASE;
                        pullupCount <= 8'(PULLUP_CYCLES);
                    end
                end
                ARB_RELEASE:
                begin
                    if (pullupDone)
                        arbState <= ARB_SLAVE;
                    pullupCount <= pullupCount - 8'h01;
                end
                default:
                    arbState <= ARB_SLAVE;
            endcase
        end
    end

    // The master flag is a flop of its own, loaded with the state that the
    // machine enters, so that it leaves the block free of decode glitches.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            isMaster <= 1'b0;
        else
        begin
            case (arbState)
                ARB_SLAVE:
                    isMaster <= takeNow;
                ARB_MASTER:
                    isMaster <= !releaseNow;
                default:
                    isMaster <= 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Busy line drive
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            bus_busy_line_out <= '{level: 1'b1, oe: 1'b0};
        else
        begin
            case (arbState)
                ARB_SLAVE:
                    if (takeNow)
                        bus_busy_line_out <= '{level: 1'b0, oe: 1'b1};
                    else
                        bus_busy_line_out <= '{level: 1'b1, oe: 1'b0};
                ARB_MASTER:
                    if (releaseNow)
                        bus_busy_line_out <= '{level: 1'b1, oe: 1'b1};
                    else
                        bus_busy_line_out <= '{level: 1'b0, oe: 1'b1};
                ARB_RELEASE:
                    if (pullupDone)
                        bus_busy_line_out <= '{level: 1'b1, oe: 1'b0};
                    else
                        bus_busy_line_out <= '{level: 1'b1, oe: 1'b1};
                default:
                    bus_busy_line_out <= '{level: 1'b1, oe: 1'b0};
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Bus request
    // ----------------------------------------------------------------
    // In stop or wait the request follows the hold bit: cleared when the
    // bit is clear, kept as it was when the bit is set.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            bus_request_out_n <= 1'b1;
        else if (lowPower)
        begin
            if (!mode.requestHoldBit)
                bus_request_out_n <= 1'b1;
        end
        else
            bus_request_out_n <= !(busNeed || mode.requestHoldBit);
    end

    // ----------------------------------------------------------------
    // Column strobe
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            columnStrobeN <= '{level: 1'b1, oe: 1'b0};
        else if (isMaster)
            columnStrobeN <= '{level: !columnStrobeAssert, oe: 1'b1};
        else if (mode.columnStrobeDriveEnable)
            columnStrobeN <= '{level: 1'b1, oe: 1'b1};
        else
            columnStrobeN <= '{level: 1'b1, oe: 1'b0};
    end

    // ----------------------------------------------------------------
    // Bus clock (link clock domain)
    // ----------------------------------------------------------------
    // The quarter-period lead over the core clock output comes from the
    // PLL that supplies the link clock; this logic halves it and gates it.
    logic masterLevel;
    logic clockEnableLevel;
    logic masterMeta;
    logic masterLink;
    logic enableMeta;
    logic enableLink;
    logic busClockLevel;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            masterLevel      <= 1'b0;
            clockEnableLevel <= 1'b0;
        end
        else
        begin
            masterLevel      <= isMaster;
            clockEnableLevel <= isMaster && mode.traceEnable;
        end
    end

    always_ff @(posedge linkClock or posedge rst)
    begin
        if (rst)
        begin
            masterMeta <= 1'b0;
            masterLink <= 1'b0;
            enableMeta <= 1'b0;
            enableLink <= 1'b0;
        end
        else
        begin
            masterMeta <= masterLevel;
            masterLink <= masterMeta;
            enableMeta <= clockEnableLevel;
            enableLink <= enableMeta;
        end
    end

    always_ff @(posedge linkClock or posedge rst)
    begin
        if (rst)
            busClockLevel <= 1'b0;
        else if (enableLink)
            busClockLevel <= !busClockLevel;
        else
            busClockLevel <= 1'b0;
    end

    always_ff @(posedge linkClock or posedge rst)
    begin
        if (rst)
        begin
            busClock  <= '{level: 1'b0, oe: 1'b0};
            busClockN <= '{level: 1'b1, oe: 1'b0};
        end
        else
        begin
            busClock  <= '{level: enableLink && !busClockLevel, oe: enableLink};
            busClockN <= '{level: !(enableLink && !busClockLevel), oe: masterLink};
        end
    end

endmodule

// ---- verification/ebm_arbiter_model.sv ----
// Model of the external arbiter and of the other master sharing the busy wire.
`timescale 1ns/1ps
module ebm_arbiter_model
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 grantWanted,
    input  wire logic                 otherBusy,
    input  wire ebm_pkg::ebm_pin_type busyDrive,
    output logic                      grantN,
    output logic                      busyWire
);
    import ebm_pkg::*;
    logic [1:0] gap;
    // Grants are spaced apart so that synchronised inputs see every removal.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            gap <= 2'h3;
        else if (!grantWanted)
            gap <= 2'h3;
        else if (gap != 2'h0)
            gap <= gap - 2'h1;
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            grantN <= 1'b1;
        else
            grantN <= !(grantWanted && gap == 2'h0);
    end
    // The pull-up holds the wire high once nobody drives it.
    assign busyWire = busyDrive.oe ? busyDrive.level : !otherBusy;
endmodule

// ---- verification/ebm_bus_mastership_asserts.sv ----
// Concurrent checks on the ports of the bus mastership block.
`timescale 1ns/1ps
module ebm_bus_mastership_asserts
#(
    parameter int PULLUP_CYCLES = 1
)
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 linkClock,
    input  wire logic                 busNeed,
    input  wire logic                 cycleActive,
    input  wire logic                 columnStrobeAssert,
    input  wire logic                 lowPower,
    input  wire logic                 isMaster,
    input  wire logic                 bus_grant_in_n,
    input  wire logic                 bus_busy_line_in,
    input  wire ebm_pkg::ebm_pin_type bus_busy_line_out,
    input  wire logic                 bus_request_out_n,
    input  wire ebm_pkg::ebm_pin_type columnStrobeN,
    input  wire ebm_pkg::ebm_pin_type busClock,
    input  wire ebm_pkg::ebm_pin_type busClockN
);
    import ebm_pkg::*;
    logic [4:0] idle;
    // The bus clock enable crosses slowly, so the off check waits a settled span.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            idle <= 5'h00;
        else if (isMaster)
            idle <= 5'h00;
        else if (idle != 5'h1F)
            idle <= idle + 5'h01;
    end
    take_after_idle_a: assert property (@(posedge clock) disable iff (rst)
        $rose(isMaster) |-> !$past(bus_grant_in_n, 3) && $past(bus_busy_line_in, 3)) else $error("early take");
    busy_held_a: assert property (@(posedge clock) disable iff (rst)
        isMaster |-> bus_busy_line_out.oe && !bus_busy_line_out.level) else $error("busy not held");
    busy_release_a: assert property (@(posedge clock) disable iff (rst)
        $fell(isMaster) |-> bus_busy_line_out.oe && bus_busy_line_out.level ##1 !bus_busy_line_out.oe)
        else $error("bad busy release");
    grant_drop_a: assert property (@(posedge clock) disable iff (rst)
        (bus_grant_in_n && !cycleActive) [*5] |-> !isMaster) else $error("no release");
    cycle_kept_a: assert property (@(posedge clock) disable iff (rst)
        isMaster && cycleActive |=> isMaster) else $error("cycle split");
    stop_ignore_a: assert property (@(posedge clock) disable iff (rst)
        !isMaster && lowPower |=> !isMaster) else $error("taken in stop");
    request_a: assert property (@(posedge clock) disable iff (rst)
        busNeed && !lowPower |=> !bus_request_out_n) else $error("request missing");
    strobe_a: assert property (@(posedge clock) disable iff (rst)
        isMaster |=> columnStrobeN.oe && columnStrobeN.level == !$past(columnStrobeAssert))
        else $error("bad strobe");
    clock_pair_a: assert property (@(posedge linkClock) disable iff (rst)
        busClockN.level != busClock.level) else $error("pair not inverse");
    clock_off_a: assert property (@(posedge clock) disable iff (rst)
        idle > 5'h1B |-> !busClock.oe && !busClockN.oe) else $error("clock driven");
endmodule

bind ebm_bus_mastership ebm_bus_mastership_asserts #(.PULLUP_CYCLES(PULLUP_CYCLES)) u_chk (.*);

// ---- verification/tb_top.sv ----
// Self-checking bench for the bus mastership block with an arbiter model.
`timescale 1ns/1ps
module tb_top;
    import ebm_pkg::*;
    logic        clock = 1'b0, rst = 1'b1, linkClock = 1'b0, isMaster, grantN, busyWire, reqN;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, v;
    logic        busNeed = 1'b0, cycleActive = 1'b0, colAssert = 1'b0, lowPower = 1'b0;
    logic        grantWanted = 1'b0, otherBusy = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    ebm_pin_type busyDrive, colN, bclk, bclkN;
    int          n_fail = 0, checks_done = 0, cycles = 0;

    always #5 clock = !clock;
    initial #1 forever #32 linkClock = !linkClock;

    ebm_bus_mastership u_dut (.clock(clock), .rst(rst), .linkClock(linkClock), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busNeed(busNeed), .cycleActive(cycleActive),
        .columnStrobeAssert(colAssert), .lowPower(lowPower), .isMaster(isMaster),
        .bus_grant_in_n(grantN), .bus_busy_line_in(busyWire), .bus_busy_line_out(busyDrive),
        .bus_request_out_n(reqN), .columnStrobeN(colN), .busClock(bclk), .busClockN(bclkN));
    ebm_arbiter_model u_arb (.clock(clock), .rst(rst), .grantWanted(grantWanted),
        .otherBusy(otherBusy), .busyDrive(busyDrive), .grantN(grantN), .busyWire(busyWire));

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            $display("wrong value at %0t: %s", $time, msg);
            n_fail++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Pready is awaited, never assumed.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_reset();
        tick(3);
        check(reqN === 1'b1 && isMaster === 1'b0 && busyDrive.oe === 1'b0, "reset state");
        check(colN.oe === 1'b0 && bclk.oe === 1'b0 && bclkN.oe === 1'b0, "reset pins");
        @(posedge clock) rst <= 1'b0;
    endtask

    task automatic t_regs();
        apb(1'b1, ADDR_MODE, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_MODE, 32'h0);
        check(rd === MODE_WRITE_MASK && err === 1'b0, "mode readback");
        apb(1'b1, 12'h008, 32'hFFFF_FFFF);
        check(err === 1'b1, "unmapped write");
        apb(1'b0, 12'h008, 32'h0);
        check(err === 1'b1 && rd === 32'h0, "unmapped read");
        apb(1'b1, ADDR_MODE, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check((rd & 32'h0000_0035) === 32'h0, "status idle");
    endtask

    task automatic t_request();
        apb(1'b1, ADDR_MODE, 32'h0000_0002);
        tick(3);
        check(reqN === 1'b0, "hold bit");
        @(posedge clock) lowPower <= 1'b1;
        busNeed <= 1'b1;
        grantWanted <= 1'b1;
        tick(3);
        check(reqN === 1'b0, "hold in stop");
        apb(1'b1, ADDR_MODE, 32'h0);
        tick(15);
        check(reqN === 1'b1 && isMaster === 1'b0, "stop state");
        @(posedge clock) grantWanted <= 1'b0;
        tick(10);
        @(posedge clock) lowPower <= 1'b0;
        tick(2);
        check(reqN === 1'b0, "request");
    endtask

    task automatic t_take(input logic [31:0] mode, input int lat);
        int n;
        apb(1'b1, ADDR_MODE, mode);
        otherBusy <= 1'b1;
        grantWanted <= 1'b1;
        tick(15);
        check(isMaster === 1'b0, "taken while busy");
        check(colN.oe === 1'b1 && colN.level === 1'b1, "idle strobe");
        @(posedge clock) otherBusy <= 1'b0;
        n = 0;
        do
        begin
            tick(1);
            n++;
        end while (isMaster !== 1'b1 && n < 10);
        check(n == lat, "take latency");
        check(busyDrive.oe === 1'b1 && busyDrive.level === 1'b0, "busy drive");
        @(posedge clock) colAssert <= 1'b1;
        tick(25);
        check(colN.oe === 1'b1 && colN.level === 1'b0, "strobe");
        check(bclk.oe === 1'b1 && bclkN.oe === 1'b1 && bclkN.level === !bclk.level, "clock pair");
        // The bus clock runs in its own domain, so its toggle is awaited, not counted.
        v = bclk.level;
        n = 0;
        do
        begin
            tick(1);
            n++;
        end while (bclk.level === v && n < 10);
        check(bclk.level === !v, "clock stuck");
        @(posedge clock) busNeed <= 1'b0;
        colAssert <= 1'b0;
        tick(10);
        check(isMaster === 1'b1 && reqN === 1'b1 && busyDrive.level === 1'b0, "parked");
        @(posedge clock) cycleActive <= 1'b1;
        grantWanted <= 1'b0;
        tick(10);
        check(isMaster === 1'b1 && busyDrive.oe === 1'b1, "cycle split");
        @(posedge clock) cycleActive <= 1'b0;
        n = 0;
        do
        begin
            tick(1);
            n++;
        end while (isMaster !== 1'b0 && n < 10);
        check(busyDrive.oe === 1'b1 && busyDrive.level === 1'b1, "busy pulse");
        tick(1);
        check(busyDrive.oe === 1'b0 && busyWire === 1'b1, "busy float");
        apb(1'b1, ADDR_MODE, 32'h0);
        busNeed <= 1'b1;
        tick(40);
        check(colN.oe === 1'b0 && bclk.oe === 1'b0 && bclkN.oe === 1'b0, "pins float");
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            $display("wrong value at %0t: timeout", $time);
            n_fail++;
            final_report();
        end
    end

    initial
    begin
        t_reset();
        t_regs();
        t_request();
        t_take(32'h0000_0041, 3);
        t_take(32'h0000_2041, 4);
        final_report();
    end
endmodule
